// ---- verilog/obj_status_pkg.sv ----
// Package with register map, flag positions and sizes for the object status block
package obj_status_pkg;
    localparam int          NUM_OBJ          = 15;
    localparam int          OBJ_W            = 4;
    localparam logic [7:0]  ADDR_PAGE        = 8'hb1;
    localparam logic [7:0]  ADDR_STATUS      = 8'hb2;
    localparam logic [7:0]  ADDR_CONTROL     = 8'hb3;
    localparam int          PAGE_OBJ_LSB     = 4;
    localparam int          BIT_LEN_WARN     = 7;
    localparam int          BIT_TX_DONE      = 6;
    localparam int          BIT_RX_DONE      = 5;
    localparam int          BIT_BIT_ERR      = 4;
    localparam int          BIT_STUFF_ERR    = 3;
    localparam int          BIT_CRC_ERR      = 2;
    localparam int          BIT_FORM_ERR     = 1;
    localparam int          BIT_ACK_ERR      = 0;
    localparam logic [3:0]  DLC_MAX          = 4'h8;
    localparam logic [2:0]  STUFF_RUN        = 3'h5;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;
    localparam int          DLC_LSB          = 0;
    localparam int          DLC_W            = 4;
    localparam logic [14:0] MASK_NONE        = 15'h0000;
    localparam logic [3:0]  OBJ_NONE         = 4'hf;
endpackage

// ---- verilog/obj_pick_if.sv ----
// Interface carrying one lowest-index pick request and its answer
`timescale 1ns/100ps
interface obj_pick_if;
    import obj_status_pkg::*;
    logic [NUM_OBJ-1:0] req;
    logic               any;
    logic [OBJ_W-1:0]   idx;
    modport master (output req, input any, input idx);
    modport slave  (input req, output any, output idx);
endinterface

// ---- verilog/obj_lowest_pick.sv ----
// Lowest-index selector among message objects
`timescale 1ns/100ps
module obj_lowest_pick
    import obj_status_pkg::*;
(
    obj_pick_if.slave pick
);
    function automatic logic [OBJ_W-1:0] lowest(input logic [NUM_OBJ-1:0] v);
        logic [OBJ_W-1:0] r;
        r = OBJ_NONE;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = OBJ_W'(i);
            end
        end
        return r;
    endfunction

    assign pick.any = (pick.req != MASK_NONE);
    assign pick.idx = lowest(pick.req);
endmodule

// ---- verilog/can_object_status_flags.sv ----
// Per-object status flags, stored length codes and transmit/receive object priority
`timescale 1ns/100ps
// Notes on behaviour
// - A received length code differing from the object's expected one sets bit 7.
// - Every received data or remote frame overwrites the object's stored length code.
// - Completion of an object's transmission sets bit 6.
// - With several objects enabled to send, the lowest index among 0 to 13 goes first.
// - Completion of an object's reception sets bit 5.
// - With several objects matching a frame, the lowest index among 0 to 13 is the only one updated.
// - While transmitting, a monitored level differing from the driven level sets bit 4.
// - Dominant read while sending recessive in arbitration, ack slot or error frame is no error.
// - A received CRC mismatching the computed one over destuffed bits sets bit 2.
// - An illegal bit in CRC delimiter, ack delimiter or end of frame sets bit 1.
// - Transmit-done, receive-done and each error flag may act as an interrupt source.
// - The status register shows the object chosen by the page object field, 0 to 14.
// - The expected length code 0 to 8 sits in the object's control register.
module can_object_status_flags
    import obj_status_pkg::*;
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst_n,
    input  wire logic [7:0]         i_sfr_addr,
    input  wire logic [7:0]         i_sfr_wdata,
    input  wire logic               i_sfr_wr,
    output      logic [7:0]         o_sfr_rdata,
    input  wire logic [NUM_OBJ-1:0] i_tx_enabled,
    output      logic               o_tx_valid,
    output      logic [OBJ_W-1:0]   o_tx_obj,
    input  wire logic               i_tx_done,
    input  wire logic [NUM_OBJ-1:0] i_rx_match,
    input  wire logic               i_rx_done,
    input  wire logic [3:0]         i_rx_dlc,
    output      logic [OBJ_W-1:0]   o_rx_obj,
    input  wire logic               i_bit_tick,
    input  wire logic               i_transmitting,
    input  wire logic               i_sent_bit,
    input  wire logic               i_monitor_bit,
    input  wire logic               i_in_arbitration,
    input  wire logic               i_in_ack_slot,
    input  wire logic               i_in_error_frame,
    input  wire logic               i_stuffed_field,
    input  wire logic               i_crc_check,
    input  wire logic [14:0]        i_crc_calc,
    input  wire logic [14:0]        i_crc_recv,
    input  wire logic               i_fixed_field,
    output      logic [NUM_OBJ-1:0] o_irq_source
);
    logic [7:0]         page;
    logic [7:0]         status    [NUM_OBJ];
    logic [7:0]         control   [NUM_OBJ];
    logic [7:0]         set_bits  [NUM_OBJ];
    logic [OBJ_W-1:0]   sel_obj;
    logic [OBJ_W-1:0]   act_obj;
    logic               act_tx;
    logic [2:0]         same_cnt;
    logic               last_bit;
    logic               mon_s1;
    logic               mon_s2;
    logic [7:0]         next_err;
    logic [OBJ_W-1:0]   tx_idx;
    logic [OBJ_W-1:0]   rx_idx;
    logic               tx_any;
    logic               rx_any;

    obj_pick_if tx_pick ();
    obj_pick_if rx_pick ();

    // Object 14 never competes: priority applies to 0..13 only
    assign tx_pick.req = {1'b0, i_tx_enabled[NUM_OBJ-2:0]};
    assign rx_pick.req = {1'b0, i_rx_match[NUM_OBJ-2:0]};
    assign tx_any      = tx_pick.any;
    assign tx_idx      = tx_pick.idx;
    assign rx_any      = rx_pick.any;
    assign rx_idx      = rx_pick.idx;

    obj_lowest_pick u_tx_pick (.pick(tx_pick));
    obj_lowest_pick u_rx_pick (.pick(rx_pick));

    assign o_tx_valid = tx_any;
    assign o_tx_obj   = tx_idx;
    assign o_rx_obj   = rx_idx;
    assign sel_obj    = page[PAGE_OBJ_LSB +: OBJ_W];

    // Bus monitor is a pin, so it is synchronised before use
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Idle bus is recessive; avoids a false level change after reset
            mon_s1 <= 1'b1;
            mon_s2 <= 1'b1;
        end else begin
            mon_s1 <= i_monitor_bit;
            mon_s2 <= mon_s1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page <= 8'h00;
        end else if (i_sfr_wr && i_sfr_addr == ADDR_PAGE) begin
            page <= i_sfr_wdata;
        end
    end

    // Object the current frame belongs to; errors are charged to it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_obj <= 4'h0;
            act_tx  <= 1'b0;
        end else if (i_transmitting && tx_any) begin
            act_obj <= tx_idx;
            act_tx  <= 1'b1;
        end else if (rx_any) begin
            act_obj <= rx_idx;
            act_tx  <= 1'b0;
        end
    end

    // Run of equal received bits inside stuffed fields
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            same_cnt <= 3'h0;
            last_bit <= 1'b1;
        end else if (i_bit_tick) begin
            last_bit <= mon_s2;
            if (!i_stuffed_field || mon_s2 != last_bit) begin
                same_cnt <= 3'h1;
            end else if (same_cnt != 3'h7) begin
                same_cnt <= same_cnt + 3'h1;
            end
        end
    end

    always_comb begin
        next_err = 8'h00;
        if (i_bit_tick) begin
            if (i_transmitting && mon_s2 != i_sent_bit &&
                !((i_in_arbitration || i_in_ack_slot || i_in_error_frame) &&
                  !mon_s2 && i_sent_bit)) begin
                next_err[BIT_BIT_ERR] = 1'b1;
            end
            if (i_stuffed_field && mon_s2 == last_bit && same_cnt >= STUFF_RUN) begin
                next_err[BIT_STUFF_ERR] = 1'b1;
            end
            if (i_crc_check && i_crc_calc != i_crc_recv) begin
                next_err[BIT_CRC_ERR] = 1'b1;
            end
            // Fixed-form fields are all recessive
            if (i_fixed_field && !mon_s2) begin
                next_err[BIT_FORM_ERR] = 1'b1;
            end
            if (i_transmitting && i_in_ack_slot && mon_s2) begin
                next_err[BIT_ACK_ERR] = 1'b1;
            end
        end
    end

    // Hardware events per object this cycle
    always_comb begin
        for (int i = 0; i < NUM_OBJ; i++) begin
            set_bits[i] = 8'h00;
            if (act_obj == OBJ_W'(i)) begin
                set_bits[i] = next_err;
            end
            if (i_tx_done && act_tx && act_obj == OBJ_W'(i)) begin
                set_bits[i][BIT_TX_DONE] = 1'b1;
            end
            if (i_rx_done && rx_any && rx_idx == OBJ_W'(i)) begin
                set_bits[i][BIT_RX_DONE] = 1'b1;
                if (i_rx_dlc != control[i][DLC_LSB +: DLC_W]) begin
                    set_bits[i][BIT_LEN_WARN] = 1'b1;
                end
            end
        end
    end

    // Per-object status: hardware set wins over software write
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                status[i] <= STATUS_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                if (i_sfr_wr && i_sfr_addr == ADDR_STATUS && sel_obj == OBJ_W'(i)) begin
                    status[i] <= i_sfr_wdata | set_bits[i];
                end else begin
                    status[i] <= status[i] | set_bits[i];
                end
            end
        end
    end

    // Control holds the expected length; reception overwrites it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                control[i] <= CONTROL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                if (i_rx_done && rx_any && rx_idx == OBJ_W'(i)) begin
                    control[i][DLC_LSB +: DLC_W] <= i_rx_dlc;
                end else if (i_sfr_wr && i_sfr_addr == ADDR_CONTROL
                             && sel_obj == OBJ_W'(i)) begin
                    control[i] <= i_sfr_wdata;
                end
            end
        end
    end

    // Object number 15 is invalid and reads zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_addr == ADDR_PAGE) begin
            o_sfr_rdata <= page;
        end else if (sel_obj == OBJ_NONE) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_addr == ADDR_STATUS) begin
            o_sfr_rdata <= status[sel_obj];
        end else if (i_sfr_addr == ADDR_CONTROL) begin
            o_sfr_rdata <= control[sel_obj];
        end else begin
            o_sfr_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_source <= MASK_NONE;
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                o_irq_source[i] <= |status[i][BIT_TX_DONE:BIT_ACK_ERR];
            end
        end
    end
endmodule

// ---- verification/can_obj_status_monitor.sv ----
// Port-level checker for the object status flags block
`timescale 1ns/100ps
module can_obj_status_monitor
    import obj_status_pkg::*;
(
    input wire logic               i_sys_clk,
    input wire logic               i_rst_n,
    input wire logic [7:0]         i_sfr_addr,
    input wire logic [7:0]         o_sfr_rdata,
    input wire logic [NUM_OBJ-1:0] i_tx_enabled,
    input wire logic               o_tx_valid,
    input wire logic [OBJ_W-1:0]   o_tx_obj,
    input wire logic               i_tx_done,
    input wire logic [NUM_OBJ-1:0] i_rx_match,
    input wire logic               i_rx_done,
    input wire logic [OBJ_W-1:0]   o_rx_obj,
    input wire logic               i_bit_tick,
    input wire logic               i_transmitting,
    input wire logic               i_sent_bit,
    input wire logic               i_monitor_bit,
    input wire logic               i_in_arbitration,
    input wire logic               i_in_ack_slot,
    input wire logic               i_in_error_frame,
    input wire logic               i_crc_check,
    input wire logic [14:0]        i_crc_calc,
    input wire logic [14:0]        i_crc_recv,
    input wire logic [NUM_OBJ-1:0] o_irq_source
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    tx_valid_a: assert property (o_tx_valid == (i_tx_enabled[13:0] != 14'h0000))
        else $error("transmit valid wrong");
    tx_lowest_a: assert property (o_tx_valid |-> o_tx_obj < 4'he && i_tx_enabled[o_tx_obj]
        && (i_tx_enabled & ((15'h0001 << o_tx_obj) - 15'h0001)) == 15'h0000)
        else $error("transmit pick not lowest");
    rx_lowest_a: assert property (o_rx_obj != OBJ_NONE |-> o_rx_obj < 4'he
        && i_rx_match[o_rx_obj] && (i_rx_match & ((15'h0001 << o_rx_obj) - 15'h0001)) == 15'h0000)
        else $error("receive pick not lowest");
    rx_none_a: assert property (i_rx_match[13:0] == 14'h0000 |-> o_rx_obj == OBJ_NONE)
        else $error("receive pick without match");
    tx_irq_a: assert property (i_tx_done && o_tx_valid |=> ##[0:1] o_irq_source[o_tx_obj])
        else $error("transmit done not flagged");
    rx_irq_a: assert property (i_rx_done && o_rx_obj != OBJ_NONE
        |=> ##[0:1] o_irq_source[o_rx_obj]) else $error("receive done not flagged");
    bit_err_a: assert property (i_bit_tick && i_transmitting && o_tx_valid
        && $stable(i_monitor_bit) && $past(i_monitor_bit, 2) == i_monitor_bit
        && i_monitor_bit != i_sent_bit
        && !(!i_monitor_bit && (i_in_error_frame || i_in_arbitration || i_in_ack_slot))
        |=> ##[0:1] o_irq_source[o_tx_obj]) else $error("bit error not flagged");
    crc_err_a: assert property (i_bit_tick && i_crc_check && !i_transmitting
        && i_crc_calc != i_crc_recv && o_rx_obj != OBJ_NONE
        |=> ##[0:1] o_irq_source[o_rx_obj]) else $error("crc error not flagged");
    rdata_zero_a: assert property ($past(i_sfr_addr) < ADDR_PAGE
        || $past(i_sfr_addr) > ADDR_CONTROL |-> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (i_tx_done && o_tx_valid);
    cover property (i_rx_done && o_rx_obj != OBJ_NONE);
    cover property (i_bit_tick && i_crc_check);
endmodule
bind can_object_status_flags can_obj_status_monitor mon_u (.*);

// ---- verification/can_bus_node_model.sv ----
// Bus line seen by the monitor input of the node under test: wired-AND with recessive pull-up
`timescale 1ns/100ps
module can_bus_node_model (
    input  wire logic i_node_tx,
    input  wire logic i_sent_bit,
    input  wire logic i_other_dom,
    input  wire logic i_force_rec,
    output      logic o_bus_level
);
    // Forced recessive models a faulty line, the only way to read 1 over a sent 0
    assign o_bus_level = i_force_rec | ((i_node_tx ? i_sent_bit : 1'h1) & ~i_other_dom);
endmodule

// ---- verification/can_object_status_flags_tb_top.sv ----
// Testbench for the object status flags block
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module can_object_status_flags_tb_top;
    import obj_status_pkg::*;
    logic i_sys_clk = 1'h0, i_rst_n = 1'h0, i_sfr_wr = 1'h0, i_tx_done = 1'h0;
    logic i_rx_done = 1'h0, i_bit_tick = 1'h0, rd_en = 1'h0, rd_q = 1'h0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, e;
    logic [NUM_OBJ-1:0] i_tx_enabled = 15'h0000, i_rx_match = 15'h0000, o_irq_source;
    logic [OBJ_W-1:0] o_tx_obj, o_rx_obj;
    logic [3:0] i_rx_dlc = 4'h0, d;
    logic [14:0] i_crc_calc = 15'h0000;
    logic [10:0] fld = 11'h000;
    logic i_monitor_bit, o_tx_valid;
    wire i_transmitting, i_sent_bit, dom, rec, i_in_arbitration, i_in_ack_slot;
    wire i_in_error_frame, i_stuffed_field, i_crc_check, bad, i_fixed_field;
    wire [14:0] i_crc_recv;
    logic [7:0] exp_q[$];
    logic [10:0] ct[11] = '{11'h700, 11'h740, 11'h720, 11'h710, 11'h4c0, 11'h620,
        11'h006, 11'h004, 11'h101, 11'h008, 11'h008};
    logic [7:0] ex[11] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01, 8'h04, 8'h00,
        8'h02, 8'h00, 8'h08};
    int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 89;
    assign {i_transmitting, i_sent_bit, dom, rec, i_in_arbitration, i_in_ack_slot,
        i_in_error_frame, i_stuffed_field, i_crc_check, bad, i_fixed_field} = fld;
    assign i_crc_recv = i_crc_calc ^ {14'h0000, bad};
    can_object_status_flags dut_u (.*);
    can_bus_node_model node_u (.i_node_tx(i_transmitting), .i_sent_bit(i_sent_bit),
        .i_other_dom(dom), .i_force_rec(rec), .o_bus_level(i_monitor_bit));
    always #12.5 i_sys_clk = ~i_sys_clk;
    function automatic logic [3:0] low(input logic [14:0] v);
        low = 4'hf;
        for (int i = 13; i >= 0; i--) begin
            if (v[i]) low = i[3:0];
        end
    endfunction
    task automatic summarize;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge i_sys_clk);
        i_sfr_addr <= a;
        i_sfr_wdata <= w;
        i_sfr_wr <= 1'h1;
        @(posedge i_sys_clk);
        i_sfr_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_sys_clk);
        i_sfr_addr <= a;
        rd_en <= 1'h1;
        exp_q.push_back(x);
        @(posedge i_sys_clk);
        rd_en <= 1'h0;
    endtask
    // Fields held 3 cycles first so the two-flop bus sync has settled
    task automatic err(input logic [10:0] c, input int n, input logic [7:0] x);
        @(posedge i_sys_clk);
        fld <= c;
        i_crc_calc <= 15'($random(seed));
        repeat (3) @(posedge i_sys_clk);
        repeat (n) begin
            @(posedge i_sys_clk);
            i_bit_tick <= 1'h1;
        end
        @(posedge i_sys_clk);
        i_bit_tick <= 1'h0;
        fld <= 11'h000;
        rd(ADDR_STATUS, x);
        wr(ADDR_STATUS, 8'h00);
    endtask
    always @(posedge i_sys_clk) begin
        rd_q <= rd_en;
        cyc <= cyc + 1;
        if (rd_q) begin
            e = exp_q.pop_front();
            `CHK(o_sfr_rdata, e)
        end
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'h1;
        rd(ADDR_STATUS, STATUS_RESET);
        rd(8'hb4, 8'h00);
        for (int k = 0; k < 6; k++) begin
            @(posedge i_sys_clk);
            i_tx_enabled <= 15'($random(seed));
            i_rx_match <= 15'($random(seed));
            @(posedge i_sys_clk);
            `CHK(o_tx_obj, low(i_tx_enabled))
            `CHK(o_rx_obj, low(i_rx_match))
        end
        // Transmitter role a cycle ahead so the done pulse finds the object latched
        @(posedge i_sys_clk);
        i_tx_enabled <= 15'h4220;
        fld <= 11'h400;
        @(posedge i_sys_clk);
        i_tx_done <= 1'h1;
        @(posedge i_sys_clk);
        i_tx_done <= 1'h0;
        fld <= 11'h000;
        wr(ADDR_PAGE, 8'h50);
        rd(ADDR_STATUS, 8'h40);
        `CHK(o_irq_source, 15'h0020)
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_PAGE, 8'h20);
        for (int k = 0; k < 4; k++) begin
            d = k ? 4'($unsigned($random(seed)) % 9) : 4'h4;
            wr(ADDR_CONTROL, 8'h04);
            @(posedge i_sys_clk);
            i_rx_match <= 15'h4084;
            i_rx_dlc <= d;
            i_rx_done <= 1'h1;
            @(posedge i_sys_clk);
            i_rx_done <= 1'h0;
            rd(ADDR_STATUS, {d != 4'h4, 2'h1, 5'h00});
            rd(ADDR_CONTROL, {4'h0, d});
            wr(ADDR_STATUS, 8'h00);
        end
        wr(ADDR_PAGE, 8'hf0);
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_STATUS, 8'h00);
        @(posedge i_sys_clk);
        i_tx_enabled <= 15'h0002;
        i_rx_match <= 15'h0002;
        wr(ADDR_PAGE, 8'h10);
        for (int k = 0; k < 11; k++) begin
            err(ct[k], (k == 9) ? 5 : (k == 10) ? 6 : 1, ex[k]);
        end
        repeat (3) @(posedge i_sys_clk);
        summarize();
    end
endmodule
